// *** rtl/ssr_pkg.sv ***
// Summary of operation
// - An eight-bit serial-in parallel-out shift register feeds an eight-bit storage register.
// - Shift and storage registers each have their own clock and their own overriding clear.
// - The cascade output carries the last shift stage for chaining devices.
// - Both clocks act only on their rising edges.
// - With both clocks tied, storage takes the shift contents from before the same edge.
// - While shift clear is low all shift stages are zero regardless of other inputs.
// - On a shift rising edge stage 0 takes serial in and each stage takes its predecessor.
// - A falling shift clock edge leaves the shift stages unchanged.
// - While store clear is low all storage bits are zero regardless of other inputs.
// - On a storage rising edge the storage register loads all shift stages at once.
// - A falling storage clock edge leaves the storage register unchanged.
package ssr_pkg;
    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [WIDTH-1:0] RESET_VAL = 8'h00;
    localparam int SYNC_STAGES = 2;

    // Pin group from the controller, sampled together
    typedef struct packed {
        logic serial_in;
        logic shift_clock;
        logic shift_clear_n;
        logic store_clock;
        logic store_clear_n;
    } ssr_pins_s;
endpackage : ssr_pkg

// *** rtl/ssr_fifo.sv ***
`timescale 1ns/1ps
module ssr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [WIDTH-1:0] i_wdata,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [WIDTH-1:0] o_rdata
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("ssr_fifo depth must be a power of two");
        end
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic push;
    logic pop;
    // ------------------------------------------------------------
    // Pointers; extra bit tells full from empty
    // ------------------------------------------------------------
    assign o_wready = (wp_q - rp_q) != (AW+1)'(DEPTH);
    assign o_rvalid = wp_q != rp_q;
    assign push = i_wvalid && o_wready;
    assign pop = o_rvalid && i_rready;
    assign o_rdata = mem[rp_q[AW-1:0]];
    // Pointer update
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop) rp_q <= rp_q + 1'b1;
        end
    end
    // Storage array, no reset needed
    always_ff @(posedge i_mclk) begin
        if (push) mem[wp_q[AW-1:0]] <= i_wdata;
    end
endmodule : ssr_fifo

// *** rtl/ssr_top.sv ***
`timescale 1ns/1ps
module ssr_top #(
    parameter int WIDTH = ssr_pkg::WIDTH,
    parameter int DEPTH = ssr_pkg::FIFO_DEPTH
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire ssr_pkg::ssr_pins_s i_pins,
    output logic o_cascade_out,
    output logic [WIDTH-1:0] o_parallel_out,
    output logic o_word_valid,
    input wire logic i_word_ready,
    output logic [WIDTH-1:0] o_word_data,
    output logic o_overrun
);
    import ssr_pkg::*;
    initial begin
        if (WIDTH < 2) begin
            $error("ssr_top width must be at least two");
        end
    end
    // ------------------------------------------------------------
    // Pin synchronisers, two flops before any use
    // ------------------------------------------------------------
    ssr_pins_s s1_q;
    ssr_pins_s s2_q;
    ssr_pins_s s3_q;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= i_pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    logic sh_rise;
    logic st_rise;
    // Rising edges only; falling edges do nothing
    assign sh_rise = s2_q.shift_clock && !s3_q.shift_clock;
    assign st_rise = s2_q.store_clock && !s3_q.store_clock;

    // ------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------
    logic [WIDTH-1:0] shift_q;
    // Clear overrides the clock; independent of the storage side
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            shift_q <= WIDTH'(RESET_VAL);
        end else if (!s2_q.shift_clear_n) begin
            shift_q <= WIDTH'(RESET_VAL);
        end else if (sh_rise) begin
            shift_q <= {shift_q[WIDTH-2:0], s2_q.serial_in};
        end
    end

    // ------------------------------------------------------------
    // Storage register and outputs
    // ------------------------------------------------------------
    logic [WIDTH-1:0] store_q;
    logic casc_q;
    // Loads old shift_q, so tied clocks lag by one pulse
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            store_q <= WIDTH'(RESET_VAL);
        end else if (!s2_q.store_clear_n) begin
            store_q <= WIDTH'(RESET_VAL);
        end else if (st_rise) begin
            store_q <= shift_q;
        end
    end
    assign o_parallel_out = store_q;
    // Cascade follows last stage one cycle later, from a flop
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            casc_q <= 1'b0;
        end else begin
            casc_q <= shift_q[WIDTH-1];
        end
    end
    assign o_cascade_out = casc_q;

    // ------------------------------------------------------------
    // Word stream: each storage load is queued for the core side unless the queue is full
    // ------------------------------------------------------------
    logic f_ready;
    logic f_valid;
    logic [WIDTH-1:0] f_data;
    logic push_q;
    logic ovr_q;
    // Push follows the load so the queued word equals the outputs
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            push_q <= 1'b0;
        end else begin
            push_q <= st_rise && s2_q.store_clear_n;
        end
    end
    // Pins cannot be stalled, so a full queue is flagged sticky
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ovr_q <= 1'b0;
        end else if (push_q && !f_ready) begin
            ovr_q <= 1'b1;
        end
    end
    assign o_overrun = ovr_q;
    ssr_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_wvalid(push_q),
        .o_wready(f_ready),
        .i_wdata(store_q),
        .o_rvalid(f_valid),
        .i_rready(i_word_ready),
        .o_rdata(f_data)
    );
    assign o_word_valid = f_valid;
    assign o_word_data = f_data;
endmodule : ssr_top

// *** sim/ssr_asserts.sv ***
`timescale 1ns/1ps
module ssr_asserts #(parameter int WIDTH = 8, parameter int DEPTH = 16) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire ssr_pkg::ssr_pins_s i_pins,
    input wire logic o_cascade_out,
    input wire logic [WIDTH-1:0] o_parallel_out,
    input wire logic o_word_valid,
    input wire logic i_word_ready,
    input wire logic [WIDTH-1:0] o_word_data,
    input wire logic o_overrun
);
    import ssr_pkg::*;
    // --------
    // Pin checks; the pin sync puts effects three samples late
    // --------
    logic sk, rk, sn, rn;
    assign {sk, sn, rk, rn} = i_pins[3:0];
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    AST_SH_CLR: assert property (!sn [*6] |-> !o_cascade_out)
        else $error("shift clear ignored");
    AST_ST_CLR: assert property (!rn [*5] |-> o_parallel_out == '0)
        else $error("store clear ignored");
    AST_LOAD: assert property ($rose(rk) && rn && sn |->
        ##3 o_parallel_out[WIDTH-1] == o_cascade_out) else $error("bad load");
    AST_PAR_CHG: assert property ($changed(o_parallel_out) |->
        $past(rk, 3) && !$past(rk, 4) || !$past(rn, 3)) else $error("par moved");
    AST_CAS_CHG: assert property ($changed(o_cascade_out) |->
        $past(sk, 4) && !$past(sk, 5) || !$past(sn, 4)) else $error("cas moved");
    AST_WORD: assert property ($rose(rk) && rn |-> ##[3:6] o_word_valid)
        else $error("word not queued");
    AST_OVR: assert property (o_overrun |=> o_overrun)
        else $error("overrun dropped");
    AST_HOLD: assert property (o_word_valid && !i_word_ready |=>
        o_word_valid && $stable(o_word_data)) else $error("head lost");
endmodule : ssr_asserts
bind ssr_top ssr_asserts #(.WIDTH(WIDTH), .DEPTH(DEPTH)) ssr_asserts_i (.*);

// *** sim/ssr_ctrl_model.sv ***
`timescale 1ns/1ps
module ssr_ctrl_model (
    input wire logic i_mclk,
    output ssr_pkg::ssr_pins_s o_pins
);
    import ssr_pkg::*;
    // --------
    // Controller pins, moved on falling edges
    // --------
    initial o_pins = 5'h05;
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_mclk);
    endtask : wait_n
    // Four cycles per level, above the three that the sync needs
    task automatic pulse(input bit shift, input bit store);
        wait_n(4);
        o_pins.shift_clock = shift;
        o_pins.store_clock = store;
        wait_n(4);
        o_pins.shift_clock = 0;
        o_pins.store_clock = 0;
    endtask : pulse
    // MSB first; tie joins the store pulse to the last shift
    task automatic send(input logic [7:0] w, input bit tie);
        for (int k = 7; k >= 0; k--) begin
            o_pins.serial_in = w[k];
            pulse(1, tie && k == 0);
        end
    endtask : send
    // A clock pulse inside the clear must be ignored
    task automatic clear(input bit store);
        o_pins.shift_clear_n = store;
        o_pins.store_clear_n = !store;
        pulse(!store, store);
        o_pins.shift_clear_n = 1;
        o_pins.store_clear_n = 1;
    endtask : clear
endmodule : ssr_ctrl_model

// *** sim/ssr_top_tb_top.sv ***
`timescale 1ns/1ps
module ssr_top_tb_top;
    import ssr_pkg::*;
    // --------
    // Bench
    // --------
    logic i_mclk = 0;
    logic i_rst = 1;
    logic rdy = 0;
    logic cas, ovr, wv;
    logic [7:0] par, wd;
    ssr_pins_s pins;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    always #25 i_mclk = ~i_mclk;
    ssr_ctrl_model ssr_ctrl_model_i (.i_mclk(i_mclk), .o_pins(pins));
    ssr_top ssr_top_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_pins(pins),
        .o_cascade_out(cas), .o_parallel_out(par), .o_word_valid(wv),
        .i_word_ready(rdy), .o_word_data(wd), .o_overrun(ovr));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("errors=%0d checks=%0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // Bounded wait for the head, then a one-cycle pop
    task automatic pop(input logic [7:0] exp);
        for (int n = 0; n < 20 && wv !== 1'h1; n++) @(negedge i_mclk);
        check(wd, exp);
        rdy = 1;
        @(negedge i_mclk);
        rdy = 0;
        @(negedge i_mclk);
    endtask : pop
    task automatic t_words;
        ssr_ctrl_model_i.send(8'hA5, 0);
        ssr_ctrl_model_i.pulse(0, 1);
        check(par, 8'hA5);
        check(cas, 1'h1);
        pop(8'hA5);
        ssr_ctrl_model_i.send(8'h3C, 1);
        check(par, 8'h9E);
        pop(8'h9E);
    endtask : t_words
    task automatic t_clear;
        ssr_ctrl_model_i.clear(1);
        check(par, 8'h00);
        ssr_ctrl_model_i.send(8'hFF, 0);
        ssr_ctrl_model_i.clear(0);
        check(cas, 1'h0);
        ssr_ctrl_model_i.pulse(0, 1);
        check(par, 8'h00);
        pop(8'h00);
    endtask : t_clear
    // Sixteen loads fill the FIFO, the next one is dropped
    task automatic t_fill;
        ssr_ctrl_model_i.send(8'h81, 0);
        repeat (16) ssr_ctrl_model_i.pulse(0, 1);
        check(ovr, 1'h0);
        ssr_ctrl_model_i.pulse(0, 1);
        check(ovr, 1'h1);
        repeat (16) pop(8'h81);
        check(wv, 1'h0);
    endtask : t_fill
    initial begin
        repeat (16) @(negedge i_mclk);
        i_rst = 0;
        t_words;
        t_clear;
        t_fill;
        report_and_stop;
    end
    // Hang guard, far above the ~480 cycles needed
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            report_and_stop;
        end
    end
endmodule : ssr_top_tb_top
